// >>> core/telemetry_map.svh
// Register offsets, field positions and reset values of the telemetry monitor
// Behaviour
// - Snapshots reach nonvolatile storage only while save-enable bit 7 of option register is set.
// - Readable telemetry registers refresh only on save function switched on then off.
// - Temperature register shows the saved temperature in whole degrees Celsius.
// - Minimum quality register keeps lowest quality seen since it was last read.
// - Writing 100 to minimum quality register restarts minimum tracking.
// - Operating-minutes register shows the minutes part of operating time.
// - Operating hours are sixteen bits: high register times 256 plus low.
// - Maintenance control register enables and configures maintenance supervision.
// - Maintenance interval is an eight-bit hour count, factory value 40.
// - Decoder reset restores the maintenance interval to 40 hours.
// - Operating-time stamp of last confirmed maintenance is readable in two registers.
// - Writing 128 to confirm register captures operating time as new stamp.
// - Confirmation write neither resets the decoder nor restores other values.
// - Device indicates hours since last stamp have exceeded the interval.
// - Overdue maintenance sets bit 3 of the error indication register.
// - Confirmation leaves error indication unchanged; overdue flag never self-clears.
`ifndef TELEMETRY_MAP_SVH
`define TELEMETRY_MAP_SVH
`define OFS_MAINT_CONFIRM   8'h08
`define OFS_ERROR_IND       8'h1E
`define OFS_USER_OPTION     8'h7A
`define OFS_SAVED_TEMP      8'h85
`define OFS_QUALITY_PCT     8'h87
`define OFS_QUALITY_MIN     8'h88
`define OFS_MAINT_CONTROL   8'h9A
`define OFS_MAINT_INTERVAL  8'h9B
`define OFS_RUN_MINUTES     8'h9C
`define OFS_RUN_HOURS_HIGH  8'h9D
`define OFS_RUN_HOURS_LOW   8'h9E
`define OFS_STAMP_A         8'h9F
`define OFS_STAMP_B         8'hA0
`define BIT_SAVE_ENABLE     7
`define BIT_OVERDUE         3
`define BIT_MAINT_ENABLE    0
`define VAL_CONFIRM         8'h80
`define VAL_QUALITY_FULL    8'h64
`define RST_INTERVAL        8'h28
`define RST_USER_OPTION     8'h00
`define RST_MAINT_CONTROL   8'h00
`define MINUTE_LAST         6'h3B
`define MINUTE_SECONDS      60
`define CLOCK_HZ            25000000
`endif

// >>> core/telemetry_pkg.sv
// Types shared by the telemetry monitor files
package telemetry_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [15:0] hours_t;
	typedef enum logic [1:0] {
		SNAP_IDLE,
		SNAP_ON,
		SNAP_STORE
	} snap_state_t;
endpackage : telemetry_pkg

// >>> core/run_time_counter.sv
// Operating minutes and hours accumulator
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_map.svh"
module run_time_counter
	import telemetry_pkg::*;
#(
	parameter int unsigned TICKS_PER_MINUTE = `CLOCK_HZ * `MINUTE_SECONDS
) (
	input  wire logic   ref_clk_i,
	input  wire logic   reset_i,
	input  wire logic   running_i,
	output logic [5:0]  minutes_o,
	output hours_t      hours_o,
	output logic        hour_tick_o
);
	logic [31:0] prescale;
	wire         minute_done = running_i && (prescale == TICKS_PER_MINUTE - 1);

	always_ff @(posedge ref_clk_i) begin
		if (reset_i || minute_done) begin
			prescale <= 32'h0000_0000;
		end else if (running_i) begin
			prescale <= prescale + 32'h0000_0001;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			minutes_o   <= 6'h00;
			hours_o     <= 16'h0000;
			hour_tick_o <= 1'b0;
		end else begin
			hour_tick_o <= 1'b0;
			if (minute_done) begin
				if (minutes_o == `MINUTE_LAST) begin
					minutes_o   <= 6'h00;
					hours_o     <= hours_o + 16'h0001;
					hour_tick_o <= 1'b1;
				end else begin
					minutes_o <= minutes_o + 6'h01;
				end
			end
		end
	end
endmodule : run_time_counter
`default_nettype wire

// >>> core/snapshot_trigger.sv
// Detects save function switched on and then off
`timescale 1ns/1ps
`default_nettype none
module snapshot_trigger
	import telemetry_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic save_snapshot_function_i,
	output logic      snapshot_o
);
	snap_state_t state;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state      <= SNAP_IDLE;
			snapshot_o <= 1'b0;
		end else begin
			snapshot_o <= 1'b0;
			case (state)
				SNAP_IDLE: begin
					if (save_snapshot_function_i) begin
						state <= SNAP_ON;
					end
				end
				SNAP_ON: begin
					// Off after on completes the toggle
					if (!save_snapshot_function_i) begin
						state      <= SNAP_IDLE;
						snapshot_o <= 1'b1;
					end
				end
				default: begin
					state <= SNAP_IDLE;
				end
			endcase
		end
	end
endmodule : snapshot_trigger
`default_nettype wire

// >>> core/telemetry_maintenance_monitor.sv
// Telemetry and maintenance tracking with configuration register port
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_map.svh"
module telemetry_maintenance_monitor
	import telemetry_pkg::*;
#(
	parameter int unsigned TICKS_PER_MINUTE = `CLOCK_HZ * `MINUTE_SECONDS
) (
	input  wire logic   ref_clk_i,
	input  wire logic   reset_i,
	input  wire logic   cfg_wr_i,
	input  wire logic   cfg_rd_i,
	input  wire byte_t  cfg_addr_i,
	input  wire byte_t  cfg_wdata_i,
	output byte_t       cfg_rdata_o,
	output logic        cfg_rvalid_o,
	input  wire logic   save_snapshot_function_i,
	input  wire logic   motor_running_i,
	input  wire byte_t  temperature_c_i,
	input  wire byte_t  signal_quality_indicator_i,
	input  wire logic   quality_sample_i,
	output logic        nv_store_o,
	output byte_t       nv_temperature_o,
	output byte_t       nv_quality_o,
	output byte_t       nv_quality_min_o,
	output logic [5:0]  nv_minutes_o,
	output hours_t      nv_hours_o,
	output hours_t      nv_stamp_o,
	output logic        maintenance_due_o
);
	byte_t       error_indication;
	byte_t       user_option_flags;
	byte_t       maintenance_control;
	byte_t       maintenance_interval_hours;
	byte_t       saved_temperature;
	byte_t       signal_quality_pct;
	byte_t       signal_quality_min;
	byte_t       live_quality_min;
	logic [5:0]  run_minutes;
	hours_t      run_hours;
	hours_t      last_service_stamp;
	logic [5:0]  live_minutes;
	hours_t      live_hours;
	logic        hour_tick;
	logic        snapshot;
	hours_t      hours_since;
	logic        overdue;
	logic        wr_option;
	logic        wr_control;
	logic        wr_interval;
	logic        wr_error;
	logic        wr_quality_reset;
	logic        wr_confirm;
	logic        rd_quality_min;
	logic        store_now;
	logic        overdue_event;
	byte_t       quality_clamped;

	run_time_counter #(
		.TICKS_PER_MINUTE (TICKS_PER_MINUTE)
	) u_run_time (
		.ref_clk_i   (ref_clk_i),
		.reset_i     (reset_i),
		.running_i   (motor_running_i),
		.minutes_o   (live_minutes),
		.hours_o     (live_hours),
		.hour_tick_o (hour_tick)
	);

	snapshot_trigger u_snap (
		.ref_clk_i                (ref_clk_i),
		.reset_i                  (reset_i),
		.save_snapshot_function_i (save_snapshot_function_i),
		.snapshot_o               (snapshot)
	);

	function automatic logic wr_hit(input byte_t ofs);
		return cfg_wr_i && (cfg_addr_i == ofs);
	endfunction : wr_hit

	function automatic logic rd_hit(input byte_t ofs);
		return cfg_rd_i && (cfg_addr_i == ofs);
	endfunction : rd_hit

	// Live input may run above full scale on a noisy track
	function automatic byte_t clamp_pct(input byte_t pct);
		return (pct > `VAL_QUALITY_FULL) ? `VAL_QUALITY_FULL : pct;
	endfunction : clamp_pct

	// Write-only and unmapped offsets read as zero
	function automatic byte_t reg_value(input byte_t ofs);
		byte_t value;
		value = 8'h00;
		case (ofs)
			`OFS_ERROR_IND:      value = error_indication;
			`OFS_USER_OPTION:    value = user_option_flags;
			`OFS_SAVED_TEMP:     value = saved_temperature;
			`OFS_QUALITY_PCT:    value = signal_quality_pct;
			`OFS_QUALITY_MIN:    value = signal_quality_min;
			`OFS_MAINT_CONTROL:  value = maintenance_control;
			`OFS_MAINT_INTERVAL: value = maintenance_interval_hours;
			`OFS_RUN_MINUTES:    value = {2'b00, run_minutes};
			`OFS_RUN_HOURS_HIGH: value = run_hours[15:8];
			`OFS_RUN_HOURS_LOW:  value = run_hours[7:0];
			`OFS_STAMP_A:        value = last_service_stamp[15:8];
			`OFS_STAMP_B:        value = last_service_stamp[7:0];
			default:             value = 8'h00;
		endcase
		return value;
	endfunction : reg_value

	// Strobes decoded once, so every register sees the same qualified write
	assign wr_option        = wr_hit(`OFS_USER_OPTION);
	assign wr_control       = wr_hit(`OFS_MAINT_CONTROL);
	assign wr_interval      = wr_hit(`OFS_MAINT_INTERVAL);
	assign wr_error         = wr_hit(`OFS_ERROR_IND);
	assign wr_quality_reset = wr_hit(`OFS_QUALITY_MIN) && (cfg_wdata_i == `VAL_QUALITY_FULL);
	assign wr_confirm       = wr_hit(`OFS_MAINT_CONFIRM) && (cfg_wdata_i == `VAL_CONFIRM);
	assign rd_quality_min   = rd_hit(`OFS_QUALITY_MIN);
	assign store_now        = snapshot && user_option_flags[`BIT_SAVE_ENABLE];
	assign overdue_event    = overdue && hour_tick;
	assign quality_clamped  = clamp_pct(signal_quality_indicator_i);

	// Save enable lives here; other option bits are kept for the host
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			user_option_flags <= `RST_USER_OPTION;
		end else if (wr_option) begin
			user_option_flags <= cfg_wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			maintenance_control <= `RST_MAINT_CONTROL;
		end else if (wr_control) begin
			maintenance_control <= cfg_wdata_i;
		end
	end

	// Confirm write never reaches this register, so the interval survives it
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			maintenance_interval_hours <= `RST_INTERVAL;
		end else if (wr_interval) begin
			maintenance_interval_hours <= cfg_wdata_i;
		end
	end

	// Live minimum; a read restarts tracking, as does writing full scale
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			live_quality_min <= `VAL_QUALITY_FULL;
		end else if (wr_quality_reset) begin
			live_quality_min <= `VAL_QUALITY_FULL;
		end else if (rd_quality_min) begin
			live_quality_min <= (quality_sample_i) ? signal_quality_indicator_i
				: `VAL_QUALITY_FULL;
		end else if (quality_sample_i && signal_quality_indicator_i < live_quality_min) begin
			live_quality_min <= signal_quality_indicator_i;
		end
	end

	// Readable copies change only on a completed save toggle
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			saved_temperature <= 8'h00;
		end else if (snapshot) begin
			saved_temperature <= temperature_c_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			signal_quality_pct <= 8'h00;
		end else if (snapshot) begin
			signal_quality_pct <= quality_clamped;
		end
	end

	// Minutes and hours taken in one edge, so the pair is always consistent
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			run_minutes <= 6'h00;
			run_hours   <= 16'h0000;
		end else if (snapshot) begin
			run_minutes <= live_minutes;
			run_hours   <= live_hours;
		end
	end

	// Restart write wins over a snapshot landing in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			signal_quality_min <= `VAL_QUALITY_FULL;
		end else if (wr_quality_reset) begin
			signal_quality_min <= `VAL_QUALITY_FULL;
		end else if (snapshot) begin
			signal_quality_min <= live_quality_min;
		end
	end

	// Confirm captures live time as stamp; no other register restored
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			last_service_stamp <= 16'h0000;
		end else if (wr_confirm) begin
			last_service_stamp <= live_hours;
		end
	end

	// Modulo difference stays right across a wrap of the hour count
	assign hours_since = live_hours - last_service_stamp;
	// Interval 0 means due once any hour has elapsed past the stamp
	assign overdue = maintenance_control[`BIT_MAINT_ENABLE]
		&& (hours_since > {8'h00, maintenance_interval_hours});

	// Overdue set wins over a software clear in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			error_indication <= 8'h00;
		end else begin
			if (wr_error) begin
				error_indication <= cfg_wdata_i;
			end
			if (overdue_event) begin
				error_indication[`BIT_OVERDUE] <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			maintenance_due_o <= 1'b0;
		end else begin
			maintenance_due_o <= overdue;
		end
	end

	// Storage strobe fires only with save enable set
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			nv_store_o <= 1'b0;
		end else begin
			nv_store_o <= store_now;
		end
	end

	// Stored telemetry moves with the strobe and holds until the next one
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			nv_temperature_o <= 8'h00;
			nv_quality_o     <= 8'h00;
			nv_quality_min_o <= 8'h00;
		end else if (store_now) begin
			nv_temperature_o <= temperature_c_i;
			nv_quality_o     <= quality_clamped;
			nv_quality_min_o <= live_quality_min;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			nv_minutes_o <= 6'h00;
			nv_hours_o   <= 16'h0000;
			nv_stamp_o   <= 16'h0000;
		end else if (store_now) begin
			nv_minutes_o <= live_minutes;
			nv_hours_o   <= live_hours;
			nv_stamp_o   <= last_service_stamp;
		end
	end

	// Read data registered one cycle after the request
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			cfg_rdata_o  <= 8'h00;
			cfg_rvalid_o <= 1'b0;
		end else begin
			cfg_rvalid_o <= cfg_rd_i;
			cfg_rdata_o  <= reg_value(cfg_addr_i);
		end
	end
endmodule : telemetry_maintenance_monitor
`default_nettype wire

// >>> sim/telemetry_chk.sv
// Port-level assertions of the telemetry monitor
`timescale 1ns/1ps
`default_nettype none
module telemetry_chk #(
	parameter int unsigned TICKS_PER_MINUTE = 4
) (
	input wire logic        ref_clk_i,
	input wire logic        reset_i,
	input wire logic        cfg_rd_i,
	input wire logic [7:0]  cfg_addr_i,
	input wire logic [7:0]  cfg_rdata_o,
	input wire logic        cfg_rvalid_o,
	input wire logic        save_snapshot_function_i,
	input wire logic        nv_store_o,
	input wire logic [7:0]  nv_temperature_o,
	input wire logic [7:0]  nv_quality_o,
	input wire logic [5:0]  nv_minutes_o,
	input wire logic [15:0] nv_hours_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	property p_rd_answer; cfg_rd_i |=> cfg_rvalid_o; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_no_stray; !cfg_rd_i |=> !cfg_rvalid_o; endproperty
	a_no_stray: assert property (p_no_stray) else $error("stray read valid");
	property p_wo_zero; cfg_rd_i && cfg_addr_i == 8'h08 |=> cfg_rdata_o == 8'h00; endproperty
	a_wo_zero: assert property (p_wo_zero) else $error("confirm reg readable");
	property p_store_pulse; nv_store_o |=> !nv_store_o; endproperty
	a_store_pulse: assert property (p_store_pulse) else $error("store too long");
	property p_store_cause; nv_store_o |-> !$past(save_snapshot_function_i, 2)
		&& $past(save_snapshot_function_i, 3); endproperty
	a_store_cause: assert property (p_store_cause) else $error("store without toggle");
	property p_temp_hold; $changed(nv_temperature_o) |-> nv_store_o; endproperty
	a_temp_hold: assert property (p_temp_hold) else $error("temp changed alone");
	property p_hours_hold; $changed(nv_hours_o) |-> nv_store_o; endproperty
	a_hours_hold: assert property (p_hours_hold) else $error("hours changed alone");
	property p_pct; nv_quality_o <= 8'h64 && nv_minutes_o <= 6'h3B; endproperty
	a_pct: assert property (p_pct) else $error("quality or minutes range");
endmodule : telemetry_chk
`default_nettype wire

// >>> sim/station_model.sv
// Command station model: register access and save function
`timescale 1ns/1ps
`default_nettype none
module station_model (
	input  wire logic       ref_clk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i,
	output logic            wr_o,
	output logic            rd_o,
	output logic [7:0]      addr_o,
	output logic [7:0]      wdata_o,
	output logic            save_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'hFF;
		wdata_o = 8'hFF;
		save_o = 1'b0;
	end
	// Idle bus shows inverted bits, so stale values never look live
	task automatic wr(input logic [7:0] a, d);
		@(negedge ref_clk_i);
		wr_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(negedge ref_clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk_i);
		rd_o = 1'b1;
		addr_o = a;
		@(negedge ref_clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
	endtask : rd
	task automatic toggle();
		@(negedge ref_clk_i);
		save_o = 1'b1;
		@(negedge ref_clk_i);
		save_o = 1'b0;
		repeat (4) @(negedge ref_clk_i);
	endtask : toggle
endmodule : station_model
`default_nettype wire

// >>> sim/tb_telemetry_maintenance_monitor.sv
// Testbench of the telemetry and maintenance monitor
`timescale 1ns/1ps
`default_nettype none
module tb_telemetry_maintenance_monitor;
	localparam int unsigned TPM = 4;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic cfg_wr, cfg_rd, save, rvalid, store, due;
	logic run = 1'b0;
	logic qs = 1'b0;
	logic [7:0] addr, wdata, rdata, nv_t, nv_q, nv_qm;
	logic [7:0] temp = 8'h00;
	logic [7:0] qual = 8'h00;
	logic [5:0] nv_m;
	logic [15:0] nv_h, nv_s;
	int n_mismatch = 0;
	int n_tests = 0;
	int n_store = 0;
	int cyc = 0;
	station_model station_model_inst (.ref_clk_i(ref_clk_i), .rdata_i(rdata),
		.rvalid_i(rvalid), .wr_o(cfg_wr), .rd_o(cfg_rd), .addr_o(addr),
		.wdata_o(wdata), .save_o(save));
	telemetry_maintenance_monitor #(.TICKS_PER_MINUTE(TPM)) telemetry_maintenance_monitor_inst (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
		.cfg_addr_i(addr), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
		.save_snapshot_function_i(save), .motor_running_i(run), .temperature_c_i(temp),
		.signal_quality_indicator_i(qual), .quality_sample_i(qs), .nv_store_o(store),
		.nv_temperature_o(nv_t), .nv_quality_o(nv_q), .nv_quality_min_o(nv_qm),
		.nv_minutes_o(nv_m), .nv_hours_o(nv_h), .nv_stamp_o(nv_s), .maintenance_due_o(due));
	initial forever #20 ref_clk_i = ~ref_clk_i;
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// Cycle ceiling well above the ~1120 cycles the tests need
	always @(posedge ref_clk_i) begin
		cyc++;
		if (store === 1'b1) n_store++;
		if (cyc == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, exp);
		logic [7:0] d;
		station_model_inst.rd(a, d);
		chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
	endtask : rc
	task automatic wr(input logic [7:0] a, d);
		station_model_inst.wr(a, d);
	endtask : wr
	task automatic smp(input logic [7:0] q);
		@(negedge ref_clk_i);
		qual = q;
		qs = 1'b1;
		@(negedge ref_clk_i);
		qs = 1'b0;
	endtask : smp
	initial begin
		repeat (16) @(negedge ref_clk_i);
		reset_i = 1'b0;
		rc(8'h9B, 8'h28);
		rc(8'h7A, 8'h00);
		rc(8'h08, 8'h00);
		rc(8'h50, 8'h00);
		temp = 8'h19;
		wr(8'h85, 8'h55);
		rc(8'h85, 8'h00);
		station_model_inst.toggle();
		rc(8'h85, 8'h19);
		chk("store disabled", 16'h0000, 16'(n_store));
		$display("test defaults and save gating done");
		wr(8'h7A, 8'h80);
		smp(8'h5A);
		smp(8'h28);
		qual = 8'h96;
		station_model_inst.toggle();
		chk("store enabled", 16'h0001, 16'(n_store));
		chk("nv temp", 16'h0019, {8'h00, nv_t});
		chk("nv quality", 16'h0064, {8'h00, nv_q});
		chk("nv minimum", 16'h0028, {8'h00, nv_qm});
		rc(8'h87, 8'h64);
		rc(8'h88, 8'h28);
		wr(8'h88, 8'h32);
		rc(8'h88, 8'h28);
		wr(8'h88, 8'h64);
		rc(8'h88, 8'h64);
		$display("test quality done");
		wr(8'h9A, 8'h01);
		wr(8'h9B, 8'h01);
		@(negedge ref_clk_i);
		run = 1'b1;
		repeat (1000) @(negedge ref_clk_i);
		run = 1'b0;
		rc(8'h1E, 8'h08);
		chk("due", 16'h0001, {15'h0000, due});
		station_model_inst.toggle();
		rc(8'h9C, 8'h0A);
		rc(8'h9D, 8'h00);
		rc(8'h9E, 8'h04);
		chk("nv hours", 16'h0004, nv_h);
		chk("nv minutes", 16'h000A, {10'h000, nv_m});
		$display("test run time done");
		wr(8'h08, 8'h7F);
		wr(8'h08, 8'h80);
		station_model_inst.toggle();
		rc(8'h9F, 8'h00);
		rc(8'hA0, 8'h04);
		chk("nv stamp", 16'h0004, nv_s);
		rc(8'h1E, 8'h08);
		rc(8'h9B, 8'h01);
		chk("due cleared", 16'h0000, {15'h0000, due});
		wr(8'h1E, 8'h00);
		rc(8'h1E, 8'h00);
		@(negedge ref_clk_i);
		reset_i = 1'b1;
		repeat (16) @(negedge ref_clk_i);
		reset_i = 1'b0;
		rc(8'h9B, 8'h28);
		$display("test maintenance done");
		give_verdict();
	end
endmodule : tb_telemetry_maintenance_monitor
bind telemetry_maintenance_monitor telemetry_chk #(.TICKS_PER_MINUTE(TICKS_PER_MINUTE)) chk_inst (
	.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
	.cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .nv_store_o(nv_store_o),
	.save_snapshot_function_i(save_snapshot_function_i), .nv_temperature_o(nv_temperature_o),
	.nv_quality_o(nv_quality_o), .nv_minutes_o(nv_minutes_o), .nv_hours_o(nv_hours_o));
`default_nettype wire
